/* hw/cdt_timers.sv */
// Four 8-bit down-counters, pair A cascadable with pulse-width mode, pair B cascaded
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
module cdt_timers
  import cdt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic [3:0]       TIMER_IRQ,
  output logic [3:0]       TIMER_OUT
);
  cdt_reg_if bus ();

  cdt_core_t        st;
  cdt_core_t        next_st;
  logic             tick;
  logic [16:0]      dv_a;
  logic [16:0]      dv_b;
  logic [1:0][16:0] dv_i;
  logic             tmo_a;
  logic             tmo_b;
  logic [1:0]       tmo_i;
  logic [3:0]       hw_clr;

  // Decrement with timeout flag: a count of one or zero ends the interval
  function automatic logic [16:0] dec16(input logic [15:0] c);
    return {c <= 16'h0001, c - 16'h0001};
  endfunction

  cdt_prescale #(
    .DIV (PRESCALE_DIV)
  ) u_pre (
    .clk   (CLK),
    .reset (RESET),
    .tick  (tick)
  );

  cdt_bus_front u_front (
    .clk         (CLK),
    .reset       (RESET),
    .address     (AVS_ADDRESS),
    .read        (AVS_READ),
    .write       (AVS_WRITE),
    .writedata   (AVS_WRITEDATA),
    .readdata    (AVS_READDATA),
    .waitrequest (AVS_WAITREQUEST),
    .bus         (bus)
  );

  // Decrement candidates; odd byte is the MSB of a cascaded pair
  assign dv_a    = dec16({st.cnt[1], st.cnt[0]});
  assign dv_b    = dec16({st.cnt[3], st.cnt[2]});
  assign dv_i[0] = dec16({8'h00, st.cnt[0]});
  assign dv_i[1] = dec16({8'h00, st.cnt[1]});

  // Timeout events, only on a prescaler tick of an enabled timer
  assign tmo_a    = tick & st.casc & st.en[0] & dv_a[16];
  assign tmo_b    = tick & st.en[2] & dv_b[16];
  assign tmo_i[0] = tick & ~st.casc & st.en[0] & dv_i[0][16];
  assign tmo_i[1] = tick & ~st.casc & st.en[1] & dv_i[1][16];

  // Next state: hardware counting first, then software writes on top
  always_comb begin
    next_st     = st;
    hw_clr      = 4'h0;
    next_st.irq = 4'h0;
    // Pair A cascaded: one 16-bit counter, reload always
    if (tick && st.casc && st.en[0]) begin
      if (!tmo_a) begin
        {next_st.cnt[1], next_st.cnt[0]} = dv_a[15:0];
      end else if (st.pwm && !st.phase) begin
        // End of high interval: load low pair, odd interrupt
        next_st.irq[1] = 1'b1;
        next_st.cnt[0] = st.rld[0];
        next_st.cnt[1] = st.rld[1];
        next_st.phase  = 1'b1;
      end else if (st.pwm) begin
        // End of low interval: load high pair, even interrupt
        next_st.irq[0] = 1'b1;
        next_st.cnt[0] = st.rhi[0];
        next_st.cnt[1] = st.rhi[1];
        next_st.phase  = 1'b0;
      end else begin
        next_st.irq[0] = 1'b1;
        next_st.cnt[0] = st.rld[0];
        next_st.cnt[1] = st.rld[1];
      end
    end
    // Pair A independent: two 8-bit timers, reload optional
    for (int i = 0; i < 2; i++) begin
      if (tick && !st.casc && st.en[i]) begin
        if (!tmo_i[i]) begin
          next_st.cnt[i] = dv_i[i][7:0];
        end else begin
          next_st.irq[i] = 1'b1;
          if (st.arl[i]) begin
            next_st.cnt[i] = st.rld[i];
          end else begin
            next_st.cnt[i] = BYTE_RST;
            hw_clr[i]      = 1'b1;
          end
        end
      end
    end
    // Pair B: always cascaded, free-running, even interrupt only
    if (tick && st.en[2]) begin
      if (!tmo_b) begin
        {next_st.cnt[3], next_st.cnt[2]} = dv_b[15:0];
      end else begin
        next_st.irq[2] = 1'b1;
        next_st.cnt[2] = st.rld[2];
        next_st.cnt[3] = st.rld[3];
      end
    end
    // A pending interrupt is not tracked, so a second zero simply pulses again
    next_st.en   = st.en & ~hw_clr;
    next_st.tout = st.tout ^ next_st.irq;
    // Software writes override the decrement write-back
    if (bus.wr) begin
      if (bus.addr == OFF_CTRL) begin
        // Start from the held count; single-shot clear still wins
        next_st.en   = bus.wdata[CTRL_EN_LSB +: 4] & ~hw_clr;
        next_st.arl  = bus.wdata[CTRL_ARL_LSB +: 2];
        next_st.casc = bus.wdata[CTRL_CASC_BIT];
        next_st.pwm  = bus.wdata[CTRL_PWM_BIT];
        if (!st.en[0] && bus.wdata[CTRL_EN_LSB]) begin
          next_st.phase = 1'b0;
        end
      end
      for (int k = 0; k < 4; k++) begin
        if (bus.addr == cdt_addr(OFF_CNT0, 2'(k))) begin
          next_st.cnt[k] = bus.wdata[7:0];
        end
        if (bus.addr == cdt_addr(OFF_RLD0, 2'(k))) begin
          next_st.rld[k] = bus.wdata[7:0];
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (bus.addr == cdt_addr(OFF_RHI0, 2'(k))) begin
          next_st.rhi[k] = bus.wdata[7:0];
        end
      end
    end
  end

  // Timers come out of reset disabled with no event pending
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Read mux is pure decode, so reading never disturbs the counters
  always_comb begin
    bus.rdata = 32'h0000_0000;
    if (bus.addr == OFF_CTRL) begin
      bus.rdata[7:0] = {st.pwm, st.casc, st.arl, st.en};
    end
    if (bus.addr == OFF_STAT) begin
      bus.rdata[STAT_TOUT_LSB +: 4] = st.tout;
      bus.rdata[STAT_PHASE_BIT]     = st.phase;
    end
    for (int k = 0; k < 4; k++) begin
      if (bus.addr == cdt_addr(OFF_CNT0, 2'(k))) begin
        bus.rdata[7:0] = st.cnt[k];
      end
      if (bus.addr == cdt_addr(OFF_RLD0, 2'(k))) begin
        bus.rdata[7:0] = st.rld[k];
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (bus.addr == cdt_addr(OFF_RHI0, 2'(k))) begin
        bus.rdata[7:0] = st.rhi[k];
      end
    end
  end

  assign TIMER_IRQ = st.irq;
  assign TIMER_OUT = st.tout;

  default clocking cdt_cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // Write to count register zero this cycle
  logic wr_cnt0;
  assign wr_cnt0 = bus.wr && (bus.addr == cdt_addr(OFF_CNT0, 2'h0));

  sequence s_low_end;
    tmo_a && st.pwm && st.phase;
  endsequence

  sequence s_high_load;
    ##1 st.irq[0] && !st.irq[1] && !st.phase &&
        ({st.cnt[1], st.cnt[0]} == $past({st.rhi[1], st.rhi[0]}));
  endsequence

  a_single_shot_stop: assert property (
    tmo_i[0] && !st.arl[0] && !wr_cnt0 |=> !st.en[0] && st.cnt[0] == 8'h00 && st.irq[0])
    else $error("single-shot timer did not stop");

  a_reload_with_irq: assert property (
    tmo_i[1] && st.arl[1] && !bus.wr |=> st.irq[1] && st.en[1] && st.cnt[1] == $past(st.rld[1]))
    else $error("auto-reload missing at timeout");

  a_hw_clear_wins: assert property (
    tmo_i[0] && !st.arl[0] && bus.wr && bus.addr == OFF_CTRL |=> !st.en[0])
    else $error("software write kept single-shot enable");

  a_sw_write_wins: assert property (
    wr_cnt0 |=> st.cnt[0] == $past(bus.wdata[7:0]))
    else $error("count write lost to decrement");

  a_eighth_clock: assert property (
    tick && st.en[2] && !tmo_b && !bus.wr
      |=> {st.cnt[3], st.cnt[2]} == $past({st.cnt[3], st.cnt[2]}) - 16'h0001 ##1
          $stable({st.cnt[3], st.cnt[2]}) [*6])
    else $error("pair B does not step once per eight clocks");

  a_pair_b_free: assert property (
    tmo_b && !bus.wr |=> st.en[2] && st.irq[2] && st.cnt[2] == $past(st.rld[2]))
    else $error("pair B did not reload and keep running");

  a_odd_irq_quiet: assert property (
    st.casc && !st.pwm |-> !next_st.irq[1] && !next_st.irq[3])
    else $error("odd interrupt raised in cascade");

  a_pwm_alternate: assert property (
    s_low_end and !bus.wr |-> s_high_load)
    else $error("pwm did not switch to high pair");

  a_output_toggle: assert property (
    |st.irq |-> (st.tout ^ $past(st.tout)) == st.irq)
    else $error("timer output did not toggle on zero");

  a_idle_quiet: assert property (
    st.en == EN_RST && !bus.wr |=> st.irq == 4'h0 && $stable(st.cnt))
    else $error("disabled timers changed state");
endmodule

/* hw/cdt_pkg.sv */
// Shared constants and state types of the cascadable down-counter timers
package cdt_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STAT = 6'h04;
  localparam logic [5:0] OFF_CNT0 = 6'h08;
  localparam logic [5:0] OFF_RLD0 = 6'h18;
  localparam logic [5:0] OFF_RHI0 = 6'h28;
  localparam logic [5:0] REG_STEP = 6'h04;
  // Control register fields
  localparam int unsigned CTRL_EN_LSB   = 0;
  localparam int unsigned CTRL_ARL_LSB  = 4;
  localparam int unsigned CTRL_CASC_BIT = 6;
  localparam int unsigned CTRL_PWM_BIT  = 7;
  // Status register fields
  localparam int unsigned STAT_TOUT_LSB  = 0;
  localparam int unsigned STAT_PHASE_BIT = 4;
  // Reset values
  localparam logic [3:0] EN_RST   = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // One count step every eighth clock
  localparam int unsigned PRESCALE_DIV = 8;

  // Core state: control, counts, reloads, event outputs
  typedef struct packed {
    logic [3:0]      en;
    logic [1:0]      arl;
    logic            casc;
    logic            pwm;
    logic            phase;
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] rld;
    logic [1:0][7:0] rhi;
    logic [3:0]      irq;
    logic [3:0]      tout;
  } cdt_core_t;

  // Bus front state: one wait cycle, captured read word
  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } cdt_front_t;

  // Byte address of the k-th register of a bank
  function automatic logic [5:0] cdt_addr(input logic [5:0] base, input logic [1:0] k);
    return base + REG_STEP * {4'h0, k};
  endfunction
endpackage

/* hw/cdt_reg_if.sv */
// Register access strobe between the bus front and the timer core
interface cdt_reg_if;
  logic        wr;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport front (output wr, output addr, output wdata, input rdata);
  modport core  (input wr, input addr, input wdata, output rdata);
endinterface

/* hw/cdt_prescale.sv */
// Free-running prescaler giving one tick every DIV clocks
module cdt_prescale
  import cdt_pkg::*;
#(
  parameter int unsigned DIV = PRESCALE_DIV
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } cdt_pre_t;

  cdt_pre_t st;
  cdt_pre_t next_st;

  // Wrap at LAST; tick is registered so the core sees a clean pulse
  always_comb begin
    next_st      = st;
    next_st.tick = (st.cnt == LAST);
    next_st.cnt  = (st.cnt == LAST) ? '0 : st.cnt + CW'(1);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  a_tick_period: assert property (@(posedge clk) disable iff (reset)
    tick |=> !tick [*7] ##1 tick)
    else $error("tick spacing is not eight clocks");
endmodule

/* hw/cdt_bus_front.sv */
// Avalon-MM slave front: one wait cycle per access, registered read data
module cdt_bus_front
  import cdt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  cdt_reg_if.front         bus
);
  cdt_front_t st;
  cdt_front_t next_st;

  // First cycle of a request waits and captures the read word
  always_comb begin
    next_st      = st;
    next_st.done = (read | write) & ~st.done;
    if (read & ~st.done) begin
      next_st.rdata = bus.rdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Write commits only at the edge where waitrequest is low
  assign waitrequest = (read | write) & ~st.done;
  assign bus.wr      = write & st.done;
  assign bus.addr    = address;
  assign bus.wdata   = writedata;
  assign readdata    = st.rdata;
endmodule

/* testbench/cdt_timers_tb.sv */
// Self-checking bench for the cascadable down-counter timers
module cdt_timers_tb
  import cdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        reset;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  irq;
  logic [3:0]  tout;
  int          failures;
  int          total_checks;
  int          cyc;
  int          n_irq [4];
  int          last_t [4];
  int          gap [4];
  logic [31:0] rd;

  cdt_timers uut (
    .CLK             (clk),
    .RESET           (reset),
    .AVS_ADDRESS     (address),
    .AVS_READ        (read),
    .AVS_WRITE       (write),
    .AVS_WRITEDATA   (writedata),
    .AVS_READDATA    (readdata),
    .AVS_WAITREQUEST (waitrequest),
    .TIMER_IRQ       (irq),
    .TIMER_OUT       (tout)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Pulse monitor: count pulses and the spacing between them per timer
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < 4; i++) begin
      if (irq[i] === 1'b1) begin
        gap[i] = cyc - last_t[i];
        last_t[i] = cyc;
        n_irq[i]++;
      end
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Avalon access: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    // A slave that never answers ends the run through the verdict
    if (n >= 50) begin
      failures++;
      finish_test();
    end
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, rd);
    check(name, rd, exp);
  endtask

  // Wait for a pulse count on one timer, at most lim cycles
  task automatic wait_n(input int b, input int target, input int lim);
    int n;
    n = 0;
    while (n_irq[b] < target && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("pulse arrived", 32'(n_irq[b] >= target), 32'h1);
  endtask

  task automatic test_reset();
    rd_chk("ctrl", OFF_CTRL, 32'h0);
    rd_chk("count0", OFF_CNT0, 32'h0);
    repeat (40) @(posedge clk);
    check("no pulses", {28'h0, 4'(n_irq[0] + n_irq[1] + n_irq[2] + n_irq[3])}, 32'h0);
  endtask

  task automatic test_regs();
    wr(OFF_CNT0, 8'h5A);
    wr(OFF_RLD0, 8'hA5);
    rd_chk("count0", OFF_CNT0, 32'h5A);
    rd_chk("reload0", OFF_RLD0, 32'hA5);
    rd_chk("unmapped", 6'h30, 32'h0);
  endtask

  // Independent timer without reload stops and drops its enable
  task automatic test_single_shot();
    int t;
    wr(OFF_CNT0, 8'h03);
    t = n_irq[0];
    wr(OFF_CTRL, 8'h01);
    wait_n(0, t + 1, 40);
    rd_chk("ctrl after shot", OFF_CTRL, 32'h0);
    rd_chk("count0 after shot", OFF_CNT0, 32'h0);
    bus(1'b0, OFF_STAT, 8'h00, rd);
    check("out0", {28'h0, rd[3:0]}, 32'h1);
    check("out0 pin", {31'h0, tout[0]}, 32'h1);
  endtask

  // Auto-reload period, reload update, count overwrite while running
  task automatic test_reload();
    int t;
    wr(OFF_CNT0 + 6'h04, 8'h02);
    wr(OFF_RLD0 + 6'h04, 8'h04);
    t = n_irq[1];
    wr(OFF_CTRL, 8'h22);
    wait_n(1, t + 2, 70);
    check("reload gap", gap[1], 32'h20);
    rd_chk("count1 reloaded", OFF_CNT0 + 6'h04, 32'h04);
    wr(OFF_RLD0 + 6'h04, 8'h02);
    wait_n(1, t + 3, 40);
    check("old reload gap", gap[1], 32'h20);
    wait_n(1, t + 4, 40);
    check("new reload gap", gap[1], 32'h10);
    wr(OFF_RLD0 + 6'h04, 8'hF0);
    wr(OFF_CNT0 + 6'h04, 8'h01);
    wait_n(1, t + 5, 20);
    wr(OFF_CTRL, 8'h00);
  endtask

  // Pair B free-runs as one 16-bit counter, even timer raises the pulse
  task automatic test_cascade();
    int t;
    wr(OFF_RLD0 + 6'h08, 8'h02);
    wr(OFF_RLD0 + 6'h0C, 8'h01);
    wr(OFF_CNT0 + 6'h08, 8'h02);
    wr(OFF_CNT0 + 6'h0C, 8'h01);
    t = n_irq[2];
    wr(OFF_CTRL, 8'h04);
    wait_n(2, t + 1, 2200);
    rd_chk("lsb", OFF_CNT0 + 6'h08, 32'h02);
    rd_chk("msb", OFF_CNT0 + 6'h0C, 32'h01);
    wait_n(2, t + 2, 2200);
    check("16-bit gap", gap[2], 32'h810);
    check("odd silent", n_irq[3], 32'h0);
    wr(OFF_CTRL, 8'h00);
  endtask

  // Pulse-width mode: high interval, then low interval, alternating pulses
  task automatic test_pwm();
    int t0;
    int t1;
    wr(OFF_RLD0, 8'h03);
    wr(OFF_RLD0 + 6'h04, 8'h00);
    wr(OFF_RHI0, 8'h05);
    wr(OFF_RHI0 + 6'h04, 8'h00);
    wr(OFF_CNT0, 8'h05);
    wr(OFF_CNT0 + 6'h04, 8'h00);
    t0 = n_irq[0];
    t1 = n_irq[1];
    wr(OFF_CTRL, 8'hC1);
    wait_n(1, t1 + 1, 60);
    bus(1'b0, OFF_STAT, 8'h00, rd);
    check("pwm phase", {31'h0, rd[STAT_PHASE_BIT]}, 32'h1);
    wait_n(0, t0 + 1, 40);
    check("low span", last_t[0] - last_t[1], 32'h18);
    wait_n(1, t1 + 2, 60);
    check("high span", last_t[1] - last_t[0], 32'h28);
    wr(OFF_CTRL, 8'h00);
  endtask

  // Watchdog sized well beyond the longest scenario
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_regs();
    test_single_shot();
    test_reload();
    test_cascade();
    test_pwm();
    finish_test();
  end
endmodule
